// ### core/ast_ctrl.v
// Operation
// - Sequence list holds up to 512 entries.
// - Entries in a group convert every 5 or 10 us.
// - Group interval programmable, zero to six hours.
// - Entries may read digital ports or counters.
// - Each entry picks 100 or 200 kHz rate.
// - Entry carries range, connection and coding.
// - Expansion channels run at the same pace.
// - Analog trigger compares level, fires on edge.
// - Analog trigger channel is any channel.
// - Digital trigger fires on level or edge.
// - Masked pattern match on a chosen port.
// - Counter trigger: reach, exceed or window.
// - Stop condition uses any trigger type.
// - Simple mode samples from start to stop.
// - Fixed pre-trigger count before trigger honoured.
// - Infinite post-trigger ends only on halt.
// - Selected range loads its constant into DAC.
// - Two tables; user writes leave factory intact.
`timescale 1ns/1ps
`include "ast_consts.vh"

module ast_ctrl #(
    parameter NPORT = 4
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire        ana_cmp,
    input  wire        dig_trig,
    input  wire [NPORT*16-1:0] din,
    input  wire        factory_prog,
    input  wire [63:0] cnt_val,
    input  wire [15:0] adc_data,
    output reg         conv_start,
    output reg  [7:0]  ent_ch,
    output reg  [3:0]  ent_rng,
    output reg         ent_diff,
    output reg         ent_bip,
    output reg         ent_fast,
    output reg  [1:0]  ent_type,
    output reg  [15:0] cal_dac,
    output reg  [15:0] trig_dac,
    output reg  [7:0]  trig_ch,
    output reg         acq_active,
    output reg         smp_valid,
    output reg  [15:0] smp_data,
    output reg  [8:0]  smp_tag
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_WAIT = 2'h1;
    localparam [1:0] S_PRE  = 2'h2;
    localparam [1:0] S_POST = 2'h3;
    localparam [31:0] FAST_I = `AST_SLOT_FAST_NS / `AST_CLK_NS;
    localparam [31:0] SLOW_I = `AST_SLOT_SLOW_NS / `AST_CLK_NS;
    localparam [31:0] TICK_I = `AST_TICK_NS / `AST_CLK_NS;
    localparam DW = NPORT * 16;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    reg [16:0] seq_mem [0:511];
    reg [15:0] cal_mem [0:31];

    reg [1:0]  mode_reg;
    reg        calusr_reg;
    reg [8:0]  last_reg;
    reg [8:0]  saddr_reg;
    reg [31:0] gap_reg;
    reg [16:0] tstart_reg;
    reg [16:0] tstop_reg;
    reg [31:0] pat_reg;
    reg [15:0] clo_reg;
    reg [15:0] chi_reg;
    reg [31:0] pre_reg;
    reg [3:0]  istat_reg;
    reg [3:0]  imask_reg;
    reg [4:0]  caddr_reg;
    reg        arm_reg;
    reg        halt_reg;
    reg        sw_reg;
    reg [1:0]  acq_reg;
    reg        gapst_reg;
    reg [8:0]  idx_reg;
    reg [11:0] slot_reg;
    reg [11:0] tick_reg;
    reg [31:0] gcnt_reg;
    reg [31:0] precnt_reg;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    reg [DW+2:0] s1_reg;
    reg [DW+2:0] s2_reg;
    reg [DW+2:0] s3_reg;
    reg [DW+2:0] f_reg;
    reg          ana_p;
    reg          dig_p;

    wire [DW+2:0] agree = ~(s2_reg ^ s3_reg);
    wire [DW-1:0] din_f = f_reg[DW-1:0];
    wire ana_f = f_reg[DW];
    wire dig_f = f_reg[DW+1];
    wire fp_f = f_reg[DW+2];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= {(DW+3){1'b0}};
            s2_reg <= {(DW+3){1'b0}};
            s3_reg <= {(DW+3){1'b0}};
            f_reg  <= {(DW+3){1'b0}};
            ana_p  <= 1'b0;
            dig_p  <= 1'b0;
        end else begin
            s1_reg <= {factory_prog, dig_trig, ana_cmp, din};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            f_reg  <= f_reg ^ ((f_reg ^ s3_reg) & agree);
            ana_p  <= ana_f;
            dig_p  <= dig_f;
        end
    end

    // ---------------------------------------------------------------
    // Trigger evaluation
    // ---------------------------------------------------------------
    function hit;
        input [16:0]   c;
        input          sw, la, pa, ld, pd;
        input [DW-1:0] dv;
        input [63:0]   cn;
        input [31:0]   pt;
        input [15:0]   lo, hi;
        reg   [15:0]   pv, cv;
        reg            lv, pr;
        begin
            pv = dv[c[`AST_T_PORT]*16 +: 16];
            cv = cn[c[`AST_T_PORT]*16 +: 16];
            lv = (c[`AST_T_SRC] == `AST_SRC_ANA) ? la : ld;
            pr = (c[`AST_T_SRC] == `AST_SRC_ANA) ? pa : pd;
            case (c[`AST_T_SRC])
                `AST_SRC_SW: hit = sw;
                `AST_SRC_ANA, `AST_SRC_DIG: begin
                    if (c[`AST_T_EDGE])
                        hit = (lv != pr) && (lv == c[`AST_T_POL]);
                    else
                        hit = (lv == c[`AST_T_POL]);
                end
                `AST_SRC_PAT:
                    hit = ((pv ^ pt[15:0]) & pt[31:16]) == 16'h0000;
                `AST_SRC_CNT: begin
                    case (c[`AST_T_CMP])
                        `AST_CMP_EQ:  hit = (cv == lo);
                        `AST_CMP_GT:  hit = (cv > lo);
                        `AST_CMP_WIN: hit = (cv >= lo) && (cv <= hi);
                        default:      hit = 1'b0;
                    endcase
                end
                default: hit = 1'b0;
            endcase
        end
    endfunction

    // Start and stop each run the evaluator on their own config word, so their types are independent.
    wire start_hit = hit(tstart_reg, sw_reg, ana_f, ana_p, dig_f, dig_p, din_f, cnt_val,
                         pat_reg, clo_reg, chi_reg);
    wire stop_hit  = hit(tstop_reg, sw_reg, ana_f, ana_p, dig_f, dig_p, din_f, cnt_val,
                         pat_reg, clo_reg, chi_reg);

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    wire acc = psel & penable & pready;
    wire wr  = acc & pwrite;
    wire [16:0] ent = seq_mem[idx_reg];
    reg  [31:0] rd_next;
    reg         bad_next;

    always @* begin
        rd_next  = 32'h00000000;
        bad_next = 1'b0;
        case (paddr)
            `AST_A_CTRL:   rd_next = {26'h0, calusr_reg, mode_reg, 3'h0};
            `AST_A_STAT:   rd_next = {20'h0, idx_reg, gapst_reg, acq_reg};
            `AST_A_LEN:    rd_next = {22'h0, {1'b0, last_reg} + 10'h001};
            `AST_A_SADDR:  rd_next = {23'h0, saddr_reg};
            `AST_A_SDATA:  rd_next = {15'h0, seq_mem[saddr_reg]};
            `AST_A_GAP:    rd_next = gap_reg;
            `AST_A_TSTART: rd_next = {15'h0, tstart_reg};
            `AST_A_TSTOP:  rd_next = {15'h0, tstop_reg};
            `AST_A_TLEVEL: rd_next = {16'h0, trig_dac};
            `AST_A_PAT:    rd_next = pat_reg;
            `AST_A_CLO:    rd_next = {16'h0, clo_reg};
            `AST_A_CHI:    rd_next = {16'h0, chi_reg};
            `AST_A_PRE:    rd_next = pre_reg;
            `AST_A_ISTAT:  rd_next = {28'h0, istat_reg};
            `AST_A_IMASK:  rd_next = {28'h0, imask_reg};
            `AST_A_CADDR:  rd_next = {27'h0, caddr_reg};
            `AST_A_CDATA:  rd_next = {16'h0, cal_mem[caddr_reg]};
            default:       bad_next = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & bad_next;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_next : 32'h00000000;
        end
    end

    // Factory table accepts writes only while the strap is asserted.
    wire cal_ok  = (caddr_reg[3:0] < `AST_NRANGE) & (caddr_reg[4] | fp_f);
    wire cal_wr  = wr & (paddr == `AST_A_CDATA);
    wire seq_wr  = wr & (paddr == `AST_A_SDATA);

    always @(posedge pclk) begin
        if (seq_wr)
            seq_mem[saddr_reg] <= pwdata[16:0];
        if (cal_wr & cal_ok)
            cal_mem[caddr_reg] <= pwdata[15:0];
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg   <= `AST_M_NOPRE_STOP;
            calusr_reg <= 1'b0;
            last_reg   <= 9'h000;
            saddr_reg  <= 9'h000;
            gap_reg    <= 32'h00000000;
            tstart_reg <= 17'h00000;
            tstop_reg  <= 17'h00000;
            trig_dac   <= 16'h0000;
            pat_reg    <= 32'h00000000;
            clo_reg    <= 16'h0000;
            chi_reg    <= 16'h0000;
            pre_reg    <= 32'h00000000;
            imask_reg  <= 4'h0;
            caddr_reg  <= 5'h00;
            arm_reg    <= 1'b0;
            halt_reg   <= 1'b0;
            sw_reg     <= 1'b0;
        end else begin
            arm_reg  <= wr & (paddr == `AST_A_CTRL) & pwdata[`AST_C_ARM];
            halt_reg <= wr & (paddr == `AST_A_CTRL) & pwdata[`AST_C_HALT];
            sw_reg   <= wr & (paddr == `AST_A_CTRL) & pwdata[`AST_C_SWTRIG];
            if (seq_wr)
                saddr_reg <= saddr_reg + 9'h001;
            if (wr) begin
                case (paddr)
                    `AST_A_CTRL: begin
                        mode_reg   <= pwdata[`AST_C_MODE];
                        calusr_reg <= pwdata[`AST_C_CALUSR];
                    end
                    `AST_A_LEN: begin
                        if (pwdata > {22'h0, `AST_SEQ_MAX})
                            last_reg <= 9'h1FF;
                        else if (pwdata[9:0] == 10'h000)
                            last_reg <= 9'h000;
                        else
                            last_reg <= pwdata[8:0] - 9'h001;
                    end
                    `AST_A_SADDR:  saddr_reg  <= pwdata[8:0];
                    `AST_A_GAP: begin
                        if (pwdata > `AST_GAP_MAX)
                            gap_reg <= `AST_GAP_MAX;
                        else
                            gap_reg <= pwdata;
                    end
                    `AST_A_TSTART: tstart_reg <= pwdata[16:0];
                    `AST_A_TSTOP:  tstop_reg  <= pwdata[16:0];
                    `AST_A_TLEVEL: trig_dac   <= pwdata[15:0];
                    `AST_A_PAT:    pat_reg    <= pwdata;
                    `AST_A_CLO:    clo_reg    <= pwdata[15:0];
                    `AST_A_CHI:    chi_reg    <= pwdata[15:0];
                    `AST_A_PRE:    pre_reg    <= pwdata;
                    `AST_A_IMASK:  imask_reg  <= pwdata[3:0];
                    `AST_A_CADDR:  caddr_reg  <= pwdata[4:0];
                    default: ;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Acquisition state machine
    // ---------------------------------------------------------------
    wire run      = (acq_reg == S_PRE) | (acq_reg == S_POST);
    wire pre_mode = (mode_reg == `AST_M_PRE_STOP) | (mode_reg == `AST_M_PRE_INF);
    wire inf_mode = (mode_reg == `AST_M_NOPRE_INF) | (mode_reg == `AST_M_PRE_INF);
    wire [11:0] per_last = ent[`AST_E_FAST] ? FAST_I[11:0] - 12'h001
                                            : SLOW_I[11:0] - 12'h001;
    wire slot_end = run & ~gapst_reg & (slot_reg == per_last);
    wire grp_end  = slot_end & (idx_reg == last_reg);
    reg  [1:0] acq_next;
    reg        ev_start;
    reg        ev_stop;

    always @* begin
        acq_next = acq_reg;
        ev_start = 1'b0;
        ev_stop  = 1'b0;
        case (acq_reg)
            S_IDLE:
                if (arm_reg)
                    acq_next = pre_mode ? S_PRE : S_WAIT;
            S_WAIT:
                if (halt_reg) begin
                    acq_next = S_IDLE;
                    ev_stop  = 1'b1;
                end else if (start_hit) begin
                    acq_next = S_POST;
                    ev_start = 1'b1;
                end
            S_PRE:
                if (halt_reg) begin
                    acq_next = S_IDLE;
                    ev_stop  = 1'b1;
                end else if (precnt_reg >= pre_reg && start_hit) begin
                    acq_next = S_POST;
                    ev_start = 1'b1;
                end
            S_POST:
                if (halt_reg || (!inf_mode && stop_hit)) begin
                    acq_next = S_IDLE;
                    ev_stop  = 1'b1;
                end
            default: acq_next = S_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_reg    <= S_IDLE;
            precnt_reg <= 32'h00000000;
            acq_active <= 1'b0;
            trig_ch    <= 8'h00;
        end else begin
            acq_reg    <= acq_next;
            acq_active <= (acq_next == S_PRE) | (acq_next == S_POST);
            // Comparator watches the stop channel once the run is in the post-trigger state.
            trig_ch    <= (acq_reg == S_POST) ? tstop_reg[`AST_T_ACH]
                                              : tstart_reg[`AST_T_ACH];
            if (acq_reg != S_PRE)
                precnt_reg <= 32'h00000000;
            else if (slot_end && precnt_reg != 32'hFFFFFFFF)
                precnt_reg <= precnt_reg + 32'h00000001;
        end
    end

    // ---------------------------------------------------------------
    // Scan sequencer
    // ---------------------------------------------------------------
    // Expansion channel numbers are only a wider code, so pacing is equal.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gapst_reg  <= 1'b0;
            idx_reg    <= 9'h000;
            slot_reg   <= 12'h000;
            tick_reg   <= 12'h000;
            gcnt_reg   <= 32'h00000000;
            conv_start <= 1'b0;
            ent_ch     <= 8'h00;
            ent_rng    <= 4'h0;
            ent_diff   <= 1'b0;
            ent_bip    <= 1'b0;
            ent_fast   <= 1'b0;
            ent_type   <= `AST_TY_ANA;
            cal_dac    <= 16'h0000;
            smp_valid  <= 1'b0;
            smp_data   <= 16'h0000;
            smp_tag    <= 9'h000;
        end else begin
            conv_start <= 1'b0;
            smp_valid  <= 1'b0;
            if (!run) begin
                gapst_reg <= 1'b0;
                idx_reg   <= 9'h000;
                slot_reg  <= 12'h000;
            end else if (gapst_reg) begin
                if (tick_reg == TICK_I[11:0] - 12'h001) begin
                    tick_reg <= 12'h000;
                    if (gcnt_reg == 32'h00000001)
                        gapst_reg <= 1'b0;
                    gcnt_reg <= gcnt_reg - 32'h00000001;
                end else begin
                    tick_reg <= tick_reg + 12'h001;
                end
            end else begin
                if (slot_reg == 12'h000) begin
                    conv_start <= 1'b1;
                    ent_ch     <= ent[`AST_E_CH];
                    ent_rng    <= ent[`AST_E_RNG];
                    ent_diff   <= ent[`AST_E_DIFF];
                    ent_bip    <= ent[`AST_E_BIP];
                    ent_fast   <= ent[`AST_E_FAST];
                    ent_type   <= ent[`AST_E_TYPE];
                    cal_dac    <= cal_mem[{calusr_reg, ent[`AST_E_RNG]}];
                end
                if (slot_end) begin
                    slot_reg  <= 12'h000;
                    smp_valid <= 1'b1;
                    smp_tag   <= idx_reg;
                    case (ent[`AST_E_TYPE])
                        `AST_TY_DIG: smp_data <= din_f[ent[1:0]*16 +: 16];
                        `AST_TY_CNT: smp_data <= cnt_val[ent[1:0]*16 +: 16];
                        default:     smp_data <= adc_data;
                    endcase
                    if (grp_end) begin
                        idx_reg   <= 9'h000;
                        gapst_reg <= (gap_reg != 32'h00000000);
                        gcnt_reg  <= gap_reg;
                        tick_reg  <= 12'h000;
                    end else begin
                        idx_reg <= idx_reg + 9'h001;
                    end
                end else begin
                    slot_reg <= slot_reg + 12'h001;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    wire [3:0] ev = {cal_wr & ~cal_ok, grp_end, ev_stop, ev_start};
    wire [3:0] clr = (wr && paddr == `AST_A_ISTAT) ? pwdata[3:0] : 4'h0;

    // A new event beats a simultaneous write-one-to-clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= 4'h0;
            irq       <= 1'b0;
        end else begin
            istat_reg <= (istat_reg & ~clr) | ev;
            irq       <= |(((istat_reg & ~clr) | ev) & imask_reg);
        end
    end

endmodule // ast_ctrl

// ### core/ast_consts.vh
`ifndef AST_CONSTS_VH
`define AST_CONSTS_VH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define AST_CLK_NS       4
`define AST_SLOT_FAST_NS 5000
`define AST_SLOT_SLOW_NS 10000
`define AST_TICK_NS      10000
`define AST_GAP_MAX      32'h80BEFC00
`define AST_SEQ_MAX      10'h200
`define AST_NRANGE       4'hD

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define AST_A_CTRL   8'h00
`define AST_A_STAT   8'h04
`define AST_A_LEN    8'h08
`define AST_A_SADDR  8'h0C
`define AST_A_SDATA  8'h10
`define AST_A_GAP    8'h14
`define AST_A_TSTART 8'h18
`define AST_A_TSTOP  8'h1C
`define AST_A_TLEVEL 8'h20
`define AST_A_PAT    8'h24
`define AST_A_CLO    8'h28
`define AST_A_CHI    8'h2C
`define AST_A_PRE    8'h30
`define AST_A_ISTAT  8'h34
`define AST_A_IMASK  8'h38
`define AST_A_CADDR  8'h3C
`define AST_A_CDATA  8'h40

// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define AST_C_ARM    0
`define AST_C_HALT   1
`define AST_C_SWTRIG 2
`define AST_C_MODE   4:3
`define AST_C_CALUSR 5
`define AST_E_CH     7:0
`define AST_E_RNG    11:8
`define AST_E_DIFF   12
`define AST_E_BIP    13
`define AST_E_FAST   14
`define AST_E_TYPE   16:15
`define AST_T_SRC    2:0
`define AST_T_EDGE   3
`define AST_T_POL    4
`define AST_T_CMP    6:5
`define AST_T_PORT   8:7
`define AST_T_ACH    16:9

// ---------------------------------------------------------------
// Codes
// ---------------------------------------------------------------
`define AST_SRC_SW   3'h0
`define AST_SRC_ANA  3'h1
`define AST_SRC_DIG  3'h2
`define AST_SRC_PAT  3'h3
`define AST_SRC_CNT  3'h4
`define AST_CMP_EQ   2'h0
`define AST_CMP_GT   2'h1
`define AST_CMP_WIN  2'h2
`define AST_M_NOPRE_STOP 2'h0
`define AST_M_PRE_STOP   2'h1
`define AST_M_NOPRE_INF  2'h2
`define AST_M_PRE_INF    2'h3
`define AST_TY_ANA   2'h0
`define AST_TY_DIG   2'h1
`define AST_TY_CNT   2'h2
`define AST_I_START  0
`define AST_I_STOP   1
`define AST_I_GROUP  2
`define AST_I_REFUSE 3

`endif

// ### verif/ast_fe_model.sv
`timescale 1ns/1ps
module ast_fe_model (
    input  wire        pclk,
    input  wire        conv_start,
    input  wire [7:0]  ent_ch,
    input  wire [15:0] trig_dac,
    input  wire [15:0] lvl,
    output reg  [15:0] adc_data,
    output wire        ana_cmp
);
    // The comparator is level only; edge detection is the block's job.
    assign ana_cmp = lvl > trig_dac;
    initial adc_data = 16'h0000;
    always @(posedge pclk) begin
        if (conv_start) begin
            adc_data <= {8'hC0, ent_ch};
        end
    end
endmodule // ast_fe_model

// ### verif/ast_ctrl_properties.sv
`timescale 1ns/1ps
module ast_ctrl_chk (
    input wire        pclk,
    input wire        presetn,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        conv_start,
    input wire [7:0]  ent_ch,
    input wire [3:0]  ent_rng,
    input wire        ent_fast,
    input wire [15:0] cal_dac,
    input wire        acq_active,
    input wire        smp_valid,
    input wire [15:0] smp_data,
    input wire [8:0]  smp_tag
);
    reg [15:0] since_q;
    reg        seen_q;
    reg        fast_q;
    // Slot spacing is only judged inside one acquisition; a re-arm may start early.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_q <= 16'h0000;
            seen_q  <= 1'b0;
            fast_q  <= 1'b0;
        end else begin
            since_q <= conv_start ? 16'h0001 : since_q + {15'h0000, since_q != 16'hFFFF};
            seen_q  <= acq_active & (seen_q | conv_start);
            fast_q  <= conv_start ? ent_fast : fast_q;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_addr_decode: assert property (pready |-> pslverr == (paddr > 8'h40 || paddr[1:0] != 2'h0))
        else $error("slave error does not match address");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside access");
    a_slot_single_pulse: assert property (conv_start |=> !conv_start)
        else $error("slot start longer than one cycle");
    a_slot_min_span: assert property (conv_start && seen_q |-> since_q >= (fast_q ? 1250 : 2500))
        else $error("slot shorter than its rate");
    a_entry_held_slot: assert property (!conv_start |-> $stable(ent_ch) && $stable(ent_rng))
        else $error("entry changed inside slot");
    a_cal_held_slot: assert property (!conv_start |-> $stable(cal_dac))
        else $error("cal constant changed inside slot");
    a_sample_held_out: assert property (!smp_valid |-> $stable(smp_data) && $stable(smp_tag))
        else $error("sample changed without valid");
    c_fast_slot: cover property (conv_start && ent_fast);
    c_sample: cover property (smp_valid);
    c_bus_error: cover property (pready && pslverr);
endmodule // ast_ctrl_chk
bind ast_ctrl ast_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .ent_ch(ent_ch), .ent_rng(ent_rng), .ent_fast(ent_fast),
    .cal_dac(cal_dac), .acq_active(acq_active), .smp_valid(smp_valid), .smp_data(smp_data),
    .smp_tag(smp_tag));

// ### verif/tb_ast_ctrl.sv
`timescale 1ns/1ps
module tb_ast_ctrl;
    // -------------------------------------------------------
    // Bench signals
    // -------------------------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dig_trig = 0, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [63:0] din = 64'h0000_0000_BEEF_C300;
    logic [15:0] lvl = 16'h0000;
    wire  [31:0] prdata;
    wire  pready, pslverr, irq, ana_cmp, conv_start, ent_diff, ent_bip, ent_fast, acq_active;
    wire  smp_valid;
    wire  [15:0] adc_data, cal_dac, trig_dac, smp_data;
    wire  [7:0]  ent_ch, trig_ch;
    wire  [3:0]  ent_rng;
    wire  [1:0]  ent_type;
    wire  [8:0]  smp_tag;
    int   miscompares = 0, checked = 0, n;
    always #2 pclk = ~pclk;
    ast_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .ana_cmp(ana_cmp), .dig_trig(dig_trig), .din(din), .factory_prog(1'b0),
        .cnt_val(64'h0), .adc_data(adc_data), .conv_start(conv_start), .ent_ch(ent_ch),
        .ent_rng(ent_rng), .ent_diff(ent_diff), .ent_bip(ent_bip), .ent_fast(ent_fast),
        .ent_type(ent_type), .cal_dac(cal_dac), .trig_dac(trig_dac), .trig_ch(trig_ch),
        .acq_active(acq_active), .smp_valid(smp_valid), .smp_data(smp_data), .smp_tag(smp_tag));
    ast_fe_model u_fe (.pclk(pclk), .conv_start(conv_start), .ent_ch(ent_ch),
        .trig_dac(trig_dac), .lvl(lvl), .adc_data(adc_data), .ana_cmp(ana_cmp));
    // -------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    function logic pick(input int s);
        return s == 0 ? conv_start : (s == 1 ? acq_active : smp_valid);
    endfunction
    // A wait that is cut short leaves n at the limit, which the caller then judges.
    task wt(input int s, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pick(s) !== v && n < lim);
    endtask
    task summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // -------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------
    task t_regs;
        apb(1'b0, 8'h44, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h00, 32'h18);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd[4:3], 2'h3);
        $display("t_regs done");
    endtask
    task t_refuse;
        apb(1'b1, 8'h38, 32'h8);
        apb(1'b1, 8'h3C, 32'h02);
        apb(1'b1, 8'h40, 32'h5555);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, 8'h34, 32'h0);
        chk(rd[3], 1'b1);
        apb(1'b1, 8'h34, 32'h8);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        $display("t_refuse done");
    endtask
    task t_scan;
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h10, 32'h4205);
        apb(1'b1, 8'h10, 32'h8201);
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h3C, 32'h12);
        apb(1'b1, 8'h40, 32'h1234);
        apb(1'b1, 8'h18, 32'h619);
        apb(1'b1, 8'h20, 32'h8000);
        apb(1'b1, 8'h00, 32'h31);
        lvl <= 16'h9000;
        wt(1, 1'b1, 1250);
        chk(acq_active, 1'b1);
        chk(trig_ch, 8'h03);
        wt(0, 1'b1, 3000);
        chk({ent_rng, ent_ch}, 12'h205);
        chk(cal_dac, 16'h1234);
        wt(0, 1'b1, 3000);
        chk(n, 1250);
        chk(ent_type, 2'h1);
        wt(0, 1'b1, 3000);
        chk(n, 2500);
        chk({smp_tag, smp_data}, {9'h001, 16'hBEEF});
        wt(2, 1'b1, 3000);
        chk({smp_tag, smp_data}, {9'h000, 16'hC005});
        apb(1'b1, 8'h00, 32'h32);
        wt(1, 1'b0, 20);
        chk(acq_active, 1'b0);
        $display("t_scan done");
    endtask
    task t_dig;
        apb(1'b1, 8'h18, 32'h1A);
        apb(1'b1, 8'h24, 32'h00FF005A);
        apb(1'b1, 8'h1C, 32'h3);
        apb(1'b1, 8'h00, 32'h21);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h1);
        dig_trig <= 1'b1;
        wt(1, 1'b1, 1250);
        chk(acq_active, 1'b1);
        din[7:0] <= 8'h5A;
        wt(1, 1'b0, 1250);
        chk(acq_active, 1'b0);
        $display("t_dig done");
    endtask
    task t_pre;
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h30, 32'h1);
        apb(1'b1, 8'h00, 32'h39);
        apb(1'b1, 8'h00, 32'h3C);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h2);
        wt(2, 1'b1, 3000);
        apb(1'b1, 8'h00, 32'h3C);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h3);
        $display("t_pre done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_refuse;
        t_scan;
        t_dig;
        t_pre;
        summarize;
    end
    initial begin
        #200000;
        miscompares++;
        summarize;
    end
endmodule // tb_ast_ctrl
